// ---- pkg/mas_defines.vh ----
/*
  Constants for the multiplexed converter scan timing block.
  Assumes a 100 MHz system clock.
*/
`ifndef MAS_DEFINES_VH
`define MAS_DEFINES_VH

// Array shape
`define MAS_NUM_CVT      5
`define MAS_NUM_CHAN     20
`define MAS_CHAN_PER_CVT 4

// Per-channel scan rate ceiling in samples per second
`define MAS_MAX_RATE     7'h64
// Shortest scan period at the ceiling, in microseconds
`define MAS_MIN_PERIOD_US 20'h02710

// Conversion rates per mode, in tenths of a hertz
`define MAS_RATE_M1 14'h000B
`define MAS_RATE_M2 14'h0012
`define MAS_RATE_M3 14'h0017
`define MAS_RATE_M4 14'h0077
`define MAS_RATE_M5 14'h008E
`define MAS_RATE_M6 14'h015E
`define MAS_RATE_M7 14'h02A8
`define MAS_RATE_M8 14'h07A8
`define MAS_RATE_M9 14'h0FAA

// Conversion time per mode, in microseconds
`define MAS_TCONV_M1 20'hDDF23
`define MAS_TCONV_M2 20'h87A24
`define MAS_TCONV_M3 20'h6A25F
`define MAS_TCONV_M4 20'h14842
`define MAS_TCONV_M5 20'h11317
`define MAS_TCONV_M6 20'h06F9B
`define MAS_TCONV_M7 20'h03972
`define MAS_TCONV_M8 20'h013EE
`define MAS_TCONV_M9 20'h009BE

// Line-rejection filter codes
`define MAS_FILT_NONE   2'h0
`define MAS_FILT_5060   2'h1
`define MAS_FILT_60     2'h2
`define MAS_FILT_STRONG 2'h3

`endif

// ---- hdl/mas_cvt_seq.v ----
/*
  One converter sequencer: keeps its own scanlist and steps through it.
  Assumes load and start are single-cycle pulses from the same clock.
*/
`timescale 1ns/100ps
`include "mas_defines.vh"

module mas_cvt_seq #(
  parameter ID = 0
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        load,
  input  wire [99:0] list,
  input  wire [4:0]  list_len,
  input  wire        start,
  input  wire [31:0] conv_cyc,
  output reg         conv_start_r,
  output reg  [4:0]  conv_chan_r,
  output reg         busy_r,
  output reg  [2:0]  cnt_r
);

  localparam S_IDLE = 2'b01;
  localparam S_CONV = 2'b10;

  reg  [1:0]  state_r;
  reg  [19:0] own_r;
  reg  [1:0]  idx_r;
  reg  [31:0] tmr_r;
  reg  [19:0] own_nxt;
  reg  [2:0]  cnt_nxt;
  reg  [4:0]  ent;
  integer     i;

  always @*
  begin
    own_nxt = 20'h00000;
    cnt_nxt = 3'h0;
    ent     = 5'h00;
    for (i = 0; i < `MAS_NUM_CHAN; i = i + 1)
    begin
      ent = list[i*5 +: 5];
      if ((i < list_len) && (ent < 5'h14) && ((ent % 5) == ID) && (cnt_nxt < 3'h4))
      begin
        own_nxt[cnt_nxt[1:0]*5 +: 5] = ent;
        cnt_nxt = cnt_nxt + 3'h1;
      end
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r      <= S_IDLE;
      own_r        <= 20'h00000;
      cnt_r        <= 3'h0;
      idx_r        <= 2'h0;
      tmr_r        <= 32'h00000000;
      conv_start_r <= 1'b0;
      conv_chan_r  <= 5'h00;
      busy_r       <= 1'b0;
    end
    else
    begin
      conv_start_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (load)
          begin
            own_r <= own_nxt;
            cnt_r <= cnt_nxt;
          end
          else if (start && (cnt_r != 3'h0))
          begin
            state_r      <= S_CONV;
            idx_r        <= 2'h0;
            tmr_r        <= conv_cyc;
            conv_start_r <= 1'b1;
            conv_chan_r  <= own_r[4:0];
            busy_r       <= 1'b1;
          end
        end
        S_CONV:
        begin
          if (tmr_r > 32'h00000001)
            tmr_r <= tmr_r - 32'h00000001;
          else if ({1'b0, idx_r} + 3'h1 < cnt_r)
          begin
            idx_r        <= idx_r + 2'h1;
            tmr_r        <= conv_cyc;
            conv_start_r <= 1'b1;
            conv_chan_r  <= own_r[(idx_r + 2'h1)*5 +: 5];
          end
          else
          begin
            state_r <= S_IDLE;
            busy_r  <= 1'b0;
          end
        end
        default:
        begin
          state_r <= S_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

endmodule // mas_cvt_seq

// ---- hdl/mas_scan_timing.v ----
/*
  Scan timing for twenty sensor inputs multiplexed onto five converters.
  Assumes a 100 MHz clock; samp_clk_pin is asynchronous, all else synchronous.
*/
// Functional notes
// - Requested rate clamps to 100 S/s; scans never start faster than that.
// - Each converter runs one of nine conversion rates, mode 1 slowest.
// - Hardware timing starts scans on sample clock; on demand on host request.
// - On demand without forced mode, mode 1 is used.
// - Hardware timed without forced mode, lowest mode sustaining the rate is picked.
// - Required conversion rate is rate times largest per-converter channel count.
// - Required rate rounds up to the next listed conversion rate.
// - Maximum rate is lesser of 100 and mode rate over max count.
// - A forced mode overrides the automatic choice regardless of rate.
// - Channel list splits into five scanlists converted concurrently.
// - Each scanlist keeps the requested order of its channels.
// - Successive channels in a scanlist are one conversion time apart.
// - Filter: mode 1 strongest, 4 combined 50/60, 5 60 only, 9 none.
// - Input n goes to converter n modulo five.
`timescale 1ns/100ps
`include "mas_defines.vh"

module mas_scan_timing #(
  parameter [11:0] TICKS_PER_US = 12'h064
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        cfg_load,
  input  wire [99:0] cfg_chan_list,
  input  wire [4:0]  cfg_chan_len,
  input  wire [6:0]  cfg_rate,
  input  wire        cfg_hw_timed,
  input  wire        cfg_mode_force,
  input  wire [3:0]  cfg_mode,
  input  wire        samp_clk_pin,
  input  wire        sw_req,
  input  wire        overrun_clr,
  output wire [4:0]  cvt_start,
  output wire [24:0] cvt_chan,
  output reg  [3:0]  active_mode_r,
  output reg  [1:0]  filt_sel_r,
  output reg  [6:0]  max_rate_r,
  output reg         scan_busy_r,
  output reg         overrun_r
);

  reg  [99:0] list_r;
  reg  [4:0]  len_r;
  reg  [6:0]  rate_r;
  reg         hw_r;
  reg         force_r;
  reg  [3:0]  fmode_r;
  reg         load_d_r;
  reg  [2:0]  sclk_sync_r;
  reg  [31:0] gap_r;
  reg  [31:0] conv_cyc_r;
  reg  [3:0]  mode_nxt;
  reg  [3:0]  auto_mode;
  reg  [13:0] mode_rate;
  reg  [19:0] mode_us;
  reg  [1:0]  filt_nxt;
  reg  [6:0]  max_nxt;
  reg  [13:0] div_q;
  reg  [2:0]  max_cnt;
  wire [13:0] req_rate;
  wire [31:0] conv_cyc_nxt;
  wire [31:0] min_gap;
  wire [4:0]  busy_v;
  wire [14:0] cnt_v;
  wire        sclk_edge;
  wire        trig;
  wire        start_ok;
  wire        go;
  wire [6:0]  rate_c;

  assign rate_c = (cfg_rate > `MAS_MAX_RATE) ? `MAS_MAX_RATE :
                  ((cfg_rate == 7'h00) ? 7'h01 : cfg_rate);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      list_r   <= 100'h0;
      len_r    <= 5'h00;
      rate_r   <= 7'h01;
      hw_r     <= 1'b0;
      force_r  <= 1'b0;
      fmode_r  <= 4'h1;
      load_d_r <= 1'b0;
    end
    else
    begin
      load_d_r <= cfg_load & ~scan_busy_r;
      if (cfg_load && !scan_busy_r)
      begin
        list_r  <= cfg_chan_list;
        len_r   <= (cfg_chan_len > 5'h14) ? 5'h14 : cfg_chan_len;
        rate_r  <= rate_c;
        hw_r    <= cfg_hw_timed;
        force_r <= cfg_mode_force && (cfg_mode != 4'h0) && (cfg_mode < 4'hA);
        fmode_r <= cfg_mode;
      end
    end
  end

  always @*
  begin
    max_cnt = cnt_v[2:0];
    if (cnt_v[5:3] > max_cnt)
      max_cnt = cnt_v[5:3];
    if (cnt_v[8:6] > max_cnt)
      max_cnt = cnt_v[8:6];
    if (cnt_v[11:9] > max_cnt)
      max_cnt = cnt_v[11:9];
    if (cnt_v[14:12] > max_cnt)
      max_cnt = cnt_v[14:12];
  end

  assign req_rate = ({7'h00, rate_r} * {11'h000, max_cnt}) * 14'h000A;

  always @*
  begin
    if (req_rate <= `MAS_RATE_M1)
      auto_mode = 4'h1;
    else if (req_rate <= `MAS_RATE_M2)
      auto_mode = 4'h2;
    else if (req_rate <= `MAS_RATE_M3)
      auto_mode = 4'h3;
    else if (req_rate <= `MAS_RATE_M4)
      auto_mode = 4'h4;
    else if (req_rate <= `MAS_RATE_M5)
      auto_mode = 4'h5;
    else if (req_rate <= `MAS_RATE_M6)
      auto_mode = 4'h6;
    else if (req_rate <= `MAS_RATE_M7)
      auto_mode = 4'h7;
    else if (req_rate <= `MAS_RATE_M8)
      auto_mode = 4'h8;
    else
      auto_mode = 4'h9;
  end

  always @*
  begin
    if (force_r)
      mode_nxt = fmode_r;
    else if (!hw_r)
      mode_nxt = 4'h1;
    else
      mode_nxt = auto_mode;
  end

  always @*
  begin
    filt_nxt = `MAS_FILT_NONE;
    case (mode_nxt)
      4'h1:
      begin
        mode_rate = `MAS_RATE_M1;
        mode_us   = `MAS_TCONV_M1;
        filt_nxt  = `MAS_FILT_STRONG;
      end
      4'h2:
      begin
        mode_rate = `MAS_RATE_M2;
        mode_us   = `MAS_TCONV_M2;
      end
      4'h3:
      begin
        mode_rate = `MAS_RATE_M3;
        mode_us   = `MAS_TCONV_M3;
      end
      4'h4:
      begin
        mode_rate = `MAS_RATE_M4;
        mode_us   = `MAS_TCONV_M4;
        filt_nxt  = `MAS_FILT_5060;
      end
      4'h5:
      begin
        mode_rate = `MAS_RATE_M5;
        mode_us   = `MAS_TCONV_M5;
        filt_nxt  = `MAS_FILT_60;
      end
      4'h6:
      begin
        mode_rate = `MAS_RATE_M6;
        mode_us   = `MAS_TCONV_M6;
      end
      4'h7:
      begin
        mode_rate = `MAS_RATE_M7;
        mode_us   = `MAS_TCONV_M7;
      end
      4'h8:
      begin
        mode_rate = `MAS_RATE_M8;
        mode_us   = `MAS_TCONV_M8;
      end
      default:
      begin
        mode_rate = `MAS_RATE_M9;
        mode_us   = `MAS_TCONV_M9;
      end
    endcase
  end

  always @*
  begin
    case (max_cnt)
      3'h2:    div_q = mode_rate / 14'h0014;
      3'h3:    div_q = mode_rate / 14'h001E;
      3'h4:    div_q = mode_rate / 14'h0028;
      default: div_q = mode_rate / 14'h000A;
    endcase
    if (div_q > {7'h00, `MAS_MAX_RATE})
      max_nxt = `MAS_MAX_RATE;
    else
      max_nxt = div_q[6:0];
  end

  assign conv_cyc_nxt = {12'h000, mode_us} * {20'h00000, TICKS_PER_US};
  assign min_gap      = {12'h000, `MAS_MIN_PERIOD_US} * {20'h00000, TICKS_PER_US};

  // Sample clock pin synchroniser and edge detect
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sclk_sync_r <= 3'h0;
    else
      sclk_sync_r <= {sclk_sync_r[1:0], samp_clk_pin};
  end

  assign sclk_edge = sclk_sync_r[1] & ~sclk_sync_r[2];

  assign trig     = hw_r ? sclk_edge : sw_req;
  assign start_ok = ~scan_busy_r && (gap_r == 32'h00000000) && ~load_d_r;
  assign go       = trig & start_ok;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_mode_r <= 4'h1;
      filt_sel_r    <= `MAS_FILT_STRONG;
      max_rate_r    <= `MAS_MAX_RATE;
      conv_cyc_r    <= 32'h00000001;
      scan_busy_r   <= 1'b0;
      overrun_r     <= 1'b0;
      gap_r         <= 32'h00000000;
    end
    else
    begin
      active_mode_r <= mode_nxt;
      filt_sel_r    <= filt_nxt;
      max_rate_r    <= max_nxt;
      conv_cyc_r    <= (conv_cyc_nxt == 32'h00000000) ? 32'h00000001 : conv_cyc_nxt;
      scan_busy_r   <= go | (|busy_v);
      if (go)
        gap_r <= min_gap - 32'h00000001;
      else if (gap_r != 32'h00000000)
        gap_r <= gap_r - 32'h00000001;
      if (trig && !start_ok)
        overrun_r <= 1'b1;
      else if (overrun_clr)
        overrun_r <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MAS_NUM_CVT; g = g + 1)
    begin : g_cvt
      mas_cvt_seq #(
        .ID (g)
      ) u_seq (
        .clk          (clk),
        .arst_n       (arst_n),
        .load         (load_d_r),
        .list         (list_r),
        .list_len     (len_r),
        .start        (go),
        .conv_cyc     (conv_cyc_r),
        .conv_start_r (cvt_start[g]),
        .conv_chan_r  (cvt_chan[g*5 +: 5]),
        .busy_r       (busy_v[g]),
        .cnt_r        (cnt_v[g*3 +: 3])
      );
    end
  endgenerate

endmodule // mas_scan_timing

// ---- tb/mas_scan_timing_props.sv ----
/*
  Port checker for the scan timing block.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module mas_scan_timing_props #(
  parameter [11:0] TICKS_PER_US = 12'h064
) (
  input wire        clk,
  input wire        arst_n,
  input wire        cfg_hw_timed,
  input wire        sw_req,
  input wire        overrun_clr,
  input wire [4:0]  cvt_start,
  input wire [24:0] cvt_chan,
  input wire [3:0]  active_mode_r,
  input wire [1:0]  filt_sel_r,
  input wire [6:0]  max_rate_r,
  input wire        scan_busy_r,
  input wire        overrun_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire [4:0] map_ok;
  genvar k;
  generate
    for (k = 0; k < 5; k = k + 1)
    begin : g_map
      assign map_ok[k] = !cvt_start[k] || ((cvt_chan[5*k +: 5] % 5) == k);
    end
  endgenerate
  chan_map_a: assert property (|cvt_start |-> &map_ok)
    else $error("converter started on a channel it does not serve");
  start_gap_a: assert property (cvt_start[0] |=> !cvt_start[0] [*8])
    else $error("conversion starts too close together");
  start_busy_a: assert property (|cvt_start |-> scan_busy_r)
    else $error("conversion start outside a scan");
  ovr_set_a: assert property (scan_busy_r && sw_req && !cfg_hw_timed |=> overrun_r)
    else $error("request during scan not flagged");
  ovr_hold_a: assert property (overrun_r && !overrun_clr |=> overrun_r)
    else $error("overrun flag lost without clear");
  mode_range_a: assert property (active_mode_r >= 4'h1 && active_mode_r <= 4'h9)
    else $error("timing mode out of range");
  filt_map_a: assert property (filt_sel_r == (active_mode_r == 4'h1 ? 2'h3 : active_mode_r == 4'h4 ? 2'h1 :
    active_mode_r == 4'h5 ? 2'h2 : 2'h0)) else $error("filter code does not match mode");
  rate_cap_a: assert property (max_rate_r <= 7'h64)
    else $error("achievable rate above ceiling");
endmodule // mas_scan_timing_props

bind mas_scan_timing mas_scan_timing_props #(.TICKS_PER_US(TICKS_PER_US)) u_props (
  .clk(clk), .arst_n(arst_n), .cfg_hw_timed(cfg_hw_timed), .sw_req(sw_req), .overrun_clr(overrun_clr),
  .cvt_start(cvt_start), .cvt_chan(cvt_chan), .active_mode_r(active_mode_r), .filt_sel_r(filt_sel_r),
  .max_rate_r(max_rate_r), .scan_busy_r(scan_busy_r), .overrun_r(overrun_r));

// ---- tb/mas_host_model.sv ----
/*
  Host side: sample clock pin and on-demand requests.
  Assumes the caller invokes its tasks from the testbench.
*/
`timescale 1ns/100ps
module mas_host_model (
  input  wire clk,
  output reg  samp_clk_pin,
  output reg  sw_req
);
  initial
  begin
    samp_clk_pin = 1'b0;
    sw_req = 1'b0;
  end
  task sw_pulse;
  begin
    @(posedge clk);
    #1 sw_req = 1'b1;
    @(posedge clk);
    #1 sw_req = 1'b0;
  end
  endtask
  task samp_set(input v);
  begin
    @(posedge clk);
    #1 samp_clk_pin = v;
  end
  endtask
endmodule // mas_host_model

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the scan timing block.
  Assumes TICKS_PER_US of 1, so mode 9 converts in 2494 cycles.
*/
`timescale 1ns/100ps
module tb_top;
  reg         clk;
  reg         arst_n;
  reg         cfg_load;
  reg  [99:0] cfg_chan_list;
  reg  [4:0]  cfg_chan_len;
  reg  [6:0]  cfg_rate;
  reg         cfg_hw_timed;
  reg         cfg_mode_force;
  reg  [3:0]  cfg_mode;
  reg         overrun_clr;
  wire        samp_clk_pin;
  wire        sw_req;
  wire [4:0]  cvt_start;
  wire [24:0] cvt_chan;
  wire [3:0]  active_mode_r;
  wire [1:0]  filt_sel_r;
  wire [6:0]  max_rate_r;
  wire        scan_busy_r;
  wire        overrun_r;
  integer     failures;
  integer     n_compared;
  integer     i;

  mas_scan_timing #(.TICKS_PER_US(12'h001)) dut (
    .clk(clk), .arst_n(arst_n), .cfg_load(cfg_load), .cfg_chan_list(cfg_chan_list),
    .cfg_chan_len(cfg_chan_len), .cfg_rate(cfg_rate), .cfg_hw_timed(cfg_hw_timed),
    .cfg_mode_force(cfg_mode_force), .cfg_mode(cfg_mode), .samp_clk_pin(samp_clk_pin), .sw_req(sw_req),
    .overrun_clr(overrun_clr), .cvt_start(cvt_start), .cvt_chan(cvt_chan), .active_mode_r(active_mode_r),
    .filt_sel_r(filt_sel_r), .max_rate_r(max_rate_r), .scan_busy_r(scan_busy_r), .overrun_r(overrun_r));
  mas_host_model u_host (.clk(clk), .samp_clk_pin(samp_clk_pin), .sw_req(sw_req));

  always #5 clk = ~clk;

  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task end_of_test;
  begin
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  // Loads a configuration and waits until the outputs follow it
  task cfg(input hw, input frc, input [3:0] md, input [6:0] rt, input [99:0] lst, input [4:0] ln);
  begin
    @(posedge clk);
    #1 cfg_hw_timed = hw;
    cfg_mode_force = frc;
    cfg_mode = md;
    cfg_rate = rt;
    cfg_chan_list = lst;
    cfg_chan_len = ln;
    cfg_load = 1'b1;
    @(posedge clk);
    #1 cfg_load = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  end
  endtask

  task t_auto;
  begin
    cfg(1'b1, 1'b0, 4'h0, 7'h64, 100'h0, 5'h01);
    chk(active_mode_r, 4'h8);
    chk(max_rate_r, 7'h64);
    chk(filt_sel_r, 2'h0);
    cfg(1'b1, 1'b0, 4'h0, 7'h0A, {5'h0F, 5'h0A, 5'h05, 5'h00}, 5'h04);
    chk(active_mode_r, 4'h7);
    chk(max_rate_r, 7'h11);
    cfg(1'b1, 1'b0, 4'h0, 7'h01, 100'h0, 5'h01);
    chk(active_mode_r, 4'h1);
    chk(filt_sel_r, 2'h3);
    cfg(1'b1, 1'b0, 4'h0, 7'h01, {5'h05, 5'h00}, 5'h02);
    chk(active_mode_r, 4'h3);
    chk(max_rate_r, 7'h01);
    chk(filt_sel_r, 2'h0);
    cfg(1'b0, 1'b0, 4'h0, 7'h64, 100'h0, 5'h01);
    chk(active_mode_r, 4'h1);
    cfg(1'b1, 1'b1, 4'h4, 7'h64, 100'h0, 5'h01);
    chk(active_mode_r, 4'h4);
    chk(filt_sel_r, 2'h1);
    cfg(1'b1, 1'b1, 4'h5, 7'h64, 100'h0, 5'h01);
    chk(filt_sel_r, 2'h2);
  end
  endtask

  task t_scan;
  begin
    cfg(1'b0, 1'b1, 4'h9, 7'h64, {5'h01, 5'h00, 5'h05}, 5'h03);
    u_host.sw_pulse;
    chk(cvt_start, 5'h03);
    chk(cvt_chan[4:0], 5'h05);
    chk(cvt_chan[9:5], 5'h01);
    chk(scan_busy_r, 1'b1);
    u_host.sw_pulse;
    @(posedge clk);
    #1 chk(overrun_r, 1'b1);
    repeat (2490) @(posedge clk);
    #1 chk(cvt_start, 5'h00);
    @(posedge clk);
    #1 chk(cvt_start, 5'h01);
    chk(cvt_chan[4:0], 5'h00);
    overrun_clr = 1'b1;
    @(posedge clk);
    #1 overrun_clr = 1'b0;
    chk(overrun_r, 1'b0);
    for (i = 0; i < 3000 && scan_busy_r !== 1'b0; i = i + 1)
      @(posedge clk);
    #1 chk(scan_busy_r, 1'b0);
    u_host.sw_pulse;
    chk(cvt_start, 5'h00);
    chk(overrun_r, 1'b1);
    overrun_clr = 1'b1;
    @(posedge clk);
    #1 overrun_clr = 1'b0;
    chk(overrun_r, 1'b0);
  end
  endtask

  task t_hw;
  begin
    cfg(1'b1, 1'b1, 4'h9, 7'h64, {5'h03}, 5'h01);
    repeat (8000) @(posedge clk);
    u_host.samp_set(1'b1);
    for (i = 0; i < 8 && cvt_start[3] !== 1'b1; i = i + 1)
      @(posedge clk) #1;
    chk(cvt_start, 5'h08);
    chk(cvt_chan[19:15], 5'h03);
    u_host.samp_set(1'b0);
  end
  endtask

  initial
  begin
    #1000000;
    failures = failures + 1;
    end_of_test;
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    cfg_load = 1'b0;
    cfg_chan_list = 100'h0;
    cfg_chan_len = 5'h00;
    cfg_rate = 7'h00;
    cfg_hw_timed = 1'b0;
    cfg_mode_force = 1'b0;
    cfg_mode = 4'h0;
    overrun_clr = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    chk(active_mode_r, 4'h1);
    chk(filt_sel_r, 2'h3);
    chk(max_rate_r, 7'h64);
    chk(cvt_start, 5'h00);
    #1 arst_n = 1'b1;
    t_auto;
    t_scan;
    t_hw;
    end_of_test;
  end
endmodule // tb_top
